// *** hdl/tmr_pkg.sv ***
/*
 * Package for the capture/compare timer: register offsets, field positions,
 * reset values, mode codes and the register-port carrier struct.
 * Assumes one 10 MHz clock shared by the timer and its register port.
 */
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_CCA = 4'h1;
  localparam logic [3:0] ADDR_CCB = 4'h2;
  localparam logic [3:0] ADDR_MODE = 4'h3;
  localparam logic [3:0] ADDR_CAPCMP = 4'h4;
  localparam logic [3:0] ADDR_OUTCTL = 4'h5;
  localparam logic [3:0] ADDR_PRESCALE = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // mode_control_reg: [3:2] operating mode, [0] overflow flag
  localparam int MODE_LO = 2;
  localparam int MODE_HI = 3;
  localparam int OVF_BIT = 0;
  // capcmp_control_reg: [0] a captures, [1] a trigger is reverse phase of
  // first trigger, [2] b captures
  localparam int CCA_CAP_BIT = 0;
  localparam int REV_PHASE_BIT = 1;
  localparam int CCB_CAP_BIT = 2;
  // output_control_reg: [0] enable output, [1] toggle on a match,
  // [2] toggle on b match, [3] toggle on first-trigger clear/capture
  localparam int OUT_EN_BIT = 0;
  localparam int TOG_A_BIT = 1;
  localparam int TOG_B_BIT = 2;
  localparam int TOG_TRIG_BIT = 3;
  // prescale_reg: [1:0] first edge select, [3:2] second edge select,
  // [15:8] count clock divider minus one
  localparam int ES1_LO = 0;
  localparam int ES2_LO = 2;
  localparam int DIV_LO = 8;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_FREE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// *** hdl/timer_capture_compare_modes.sv ***
/*
 * 16-bit up-counter with two capture/compare registers, clear-and-start on
 * first-trigger edge and free-running modes, plus a toggling pulse output.
 * Assumes trigger pins are asynchronous; register port is on clk.
 */
// Local design decisions: the address map and the plain strobed port.
// Notes on behaviour
// - Mode bits 10 select clear-and-start on first-trigger edge.
// - Trigger edge valid only after two equal samples on the count clock.
// - In clear-and-start mode a valid first-trigger edge zeroes the counter.
// - Reverse phase loads register a on the opposite edge, no first interrupt.
// - Reverse phase: second-trigger edge raises first interrupt, no capture.
// - Toggle output on trigger clear and on match with register b.
// - Both capturing: first-trigger edge captures into b, clears, toggles.
// - Without first-trigger edges the output toggles only on enabled compare matches.
// - Pulse width: a captures rising (reverse phase), b captures falling.
// - Counter register read returns the current count.
// - Match with compare register a raises first interrupt, no clearing.
// - Match with compare register b raises second interrupt, no clearing.
// - Register a captures on the selected trigger's valid edge.
// - Register b captures only on the first trigger's valid edge.
// - Mode bits 01 count continuously, never cleared by a match.
// - After FFFF the next tick sets overflow and wraps to zero.
// - Free-running compares toggle output and raise matching interrupt.
// - Free-running b capture stores count and raises second interrupt.
`timescale 1ns/1ns
module timer_capture_compare_modes #(
  parameter int COUNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire tmr_pkg::reg_req_s req,
  output logic [15:0] rdata,
  input wire logic first_trigger_input,
  input wire logic second_trigger_input,
  output logic pulse_output,
  output logic first_interrupt,
  output logic second_interrupt
);

  // Only a 16-bit counter is built; any other width is refused
  if (COUNT_W != 16) begin : g_bad_width
    $error("COUNT_W must be 16");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] t1_sync_r, t1_sync_nxt;
  logic [1:0] t2_sync_r, t2_sync_nxt;

  // Two flops; only the second stage is read further on
  always_comb begin
    t1_sync_nxt = {t1_sync_r[0], first_trigger_input};
    t2_sync_nxt = {t2_sync_r[0], second_trigger_input};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t1_sync_r <= 2'h0;
      t2_sync_r <= 2'h0;
    end else if (ce) begin
      t1_sync_r <= t1_sync_nxt;
      t2_sync_r <= t2_sync_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] count_r, count_nxt;
  logic [15:0] cca_r, cca_nxt;
  logic [15:0] ccb_r, ccb_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic [2:0] capcmp_r, capcmp_nxt;
  logic [3:0] outctl_r, outctl_nxt;
  logic [15:0] prescale_r, prescale_nxt;
  logic [7:0] div_r, div_nxt;
  logic pout_r, pout_nxt;
  logic irq1_r, irq1_nxt;
  logic irq2_r, irq2_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  // Filter history: two samples per trigger, taken on count ticks
  logic [1:0] f1_r, f1_nxt;
  logic [1:0] f2_r, f2_nxt;
  logic lvl1_r, lvl1_nxt;
  logic lvl2_r, lvl2_nxt;

  logic tick;
  logic [1:0] opmode;
  logic run;
  logic rise1, fall1, rise2, fall2;
  logic edge1, edge2, rev1;
  logic cap_a_ev, cap_b_ev, clr_ev, irq1_ev, irq2_ev, match_a, match_b;

  // True when an edge is of the selected kind
  function automatic logic edge_sel(input logic [1:0] sel, input logic r, input logic f);
    unique case (sel)
      tmr_pkg::EDGE_FALL: edge_sel = f;
      tmr_pkg::EDGE_RISE: edge_sel = r;
      tmr_pkg::EDGE_BOTH: edge_sel = r | f;
      default: edge_sel = 1'b0;
    endcase
  endfunction

  // Event decode; a register write never blocks the timer
  always_comb begin
    opmode = mode_r[tmr_pkg::MODE_HI:tmr_pkg::MODE_LO];
    run = (opmode == tmr_pkg::MODE_FREE) || (opmode == tmr_pkg::MODE_CLEAR);
    tick = run && (div_r == 8'h00);
    // Level accepted only when two consecutive samples agree
    lvl1_nxt = (tick && (f1_r[1] == f1_r[0])) ? f1_r[0] : lvl1_r;
    lvl2_nxt = (tick && (f2_r[1] == f2_r[0])) ? f2_r[0] : lvl2_r;
    f1_nxt = tick ? {f1_r[0], t1_sync_r[1]} : f1_r;
    f2_nxt = tick ? {f2_r[0], t2_sync_r[1]} : f2_r;
    rise1 = lvl1_nxt & ~lvl1_r;
    fall1 = ~lvl1_nxt & lvl1_r;
    rise2 = lvl2_nxt & ~lvl2_r;
    fall2 = ~lvl2_nxt & lvl2_r;
    edge1 = edge_sel(prescale_r[tmr_pkg::ES1_LO +: 2], rise1, fall1);
    edge2 = edge_sel(prescale_r[tmr_pkg::ES2_LO +: 2], rise2, fall2);
    // Opposite of the first trigger's valid edge
    rev1 = edge_sel(prescale_r[tmr_pkg::ES1_LO +: 2], fall1, rise1);
    match_a = tick && !capcmp_r[tmr_pkg::CCA_CAP_BIT] && (count_r == cca_r);
    match_b = tick && !capcmp_r[tmr_pkg::CCB_CAP_BIT] && (count_r == ccb_r);
    cap_a_ev = capcmp_r[tmr_pkg::CCA_CAP_BIT] &&
      (capcmp_r[tmr_pkg::REV_PHASE_BIT] ? rev1 : edge2);
    cap_b_ev = capcmp_r[tmr_pkg::CCB_CAP_BIT] && edge1;
    clr_ev = (opmode == tmr_pkg::MODE_CLEAR) && edge1;
    // Reverse-phase captures are silent; second trigger still interrupts
    irq1_ev = match_a || (capcmp_r[tmr_pkg::CCA_CAP_BIT] && edge2);
    irq2_ev = match_b || cap_b_ev;
  end

  // Counter, captures, output and register port
  always_comb begin
    div_nxt = div_r;
    count_nxt = count_r;
    cca_nxt = cca_r;
    ccb_nxt = ccb_r;
    mode_nxt = mode_r;
    capcmp_nxt = capcmp_r;
    outctl_nxt = outctl_r;
    prescale_nxt = prescale_r;
    pout_nxt = pout_r;
    rdata_nxt = 16'h0000;
    if (run) begin
      div_nxt = (div_r == 8'h00) ? prescale_r[tmr_pkg::DIV_LO +: 8] : div_r - 8'h01;
    end else begin
      div_nxt = 8'h00;
    end
    // Software writes first so hardware events below override them
    if (req.wr) begin
      unique case (req.addr)
        tmr_pkg::ADDR_CCA: cca_nxt = req.wdata;
        tmr_pkg::ADDR_CCB: ccb_nxt = req.wdata;
        tmr_pkg::ADDR_MODE: mode_nxt = req.wdata[3:0];
        tmr_pkg::ADDR_CAPCMP: capcmp_nxt = req.wdata[2:0];
        tmr_pkg::ADDR_OUTCTL: outctl_nxt = req.wdata[3:0];
        tmr_pkg::ADDR_PRESCALE: prescale_nxt = req.wdata;
        default: ;
      endcase
    end
    // Stopping the timer zeroes the counter and releases the output
    if (!run) begin
      count_nxt = tmr_pkg::COUNT_ZERO;
      pout_nxt = 1'b0;
    end else if (clr_ev) begin
      count_nxt = tmr_pkg::COUNT_ZERO;
    end else if (tick) begin
      count_nxt = count_r + 16'h0001;
      if (count_r == tmr_pkg::COUNT_MAX) begin
        mode_nxt[tmr_pkg::OVF_BIT] = 1'b1;
      end
    end
    // Captures take the count before any clear in this cycle
    if (cap_a_ev) begin
      cca_nxt = count_r;
    end
    if (cap_b_ev) begin
      ccb_nxt = count_r;
    end
    // Only listed events toggle, so with no first edge only enabled matches move it
    if (run && outctl_r[tmr_pkg::OUT_EN_BIT]) begin
      if ((match_a && outctl_r[tmr_pkg::TOG_A_BIT]) ^
          (match_b && outctl_r[tmr_pkg::TOG_B_BIT]) ^
          (edge1 && outctl_r[tmr_pkg::TOG_TRIG_BIT] &&
           (clr_ev || cap_b_ev))) begin
        pout_nxt = ~pout_r;
      end
    end
    if (req.rd) begin
      unique case (req.addr)
        tmr_pkg::ADDR_COUNT: rdata_nxt = count_r;
        tmr_pkg::ADDR_CCA: rdata_nxt = cca_r;
        tmr_pkg::ADDR_CCB: rdata_nxt = ccb_r;
        tmr_pkg::ADDR_MODE: rdata_nxt = {12'h000, mode_r};
        tmr_pkg::ADDR_CAPCMP: rdata_nxt = {13'h0000, capcmp_r};
        tmr_pkg::ADDR_OUTCTL: rdata_nxt = {12'h000, outctl_r};
        tmr_pkg::ADDR_PRESCALE: rdata_nxt = prescale_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
    irq1_nxt = irq1_ev;
    irq2_nxt = irq2_ev;
  end

  // Register stage; ce low freezes everything
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= 8'h00;
      count_r <= tmr_pkg::COUNT_ZERO;
      cca_r <= tmr_pkg::REG_RESET;
      ccb_r <= tmr_pkg::REG_RESET;
      mode_r <= 4'h0;
      capcmp_r <= 3'h0;
      outctl_r <= 4'h0;
      prescale_r <= tmr_pkg::REG_RESET;
      pout_r <= 1'b0;
      irq1_r <= 1'b0;
      irq2_r <= 1'b0;
      rdata_r <= 16'h0000;
      f1_r <= 2'h0;
      f2_r <= 2'h0;
      lvl1_r <= 1'b0;
      lvl2_r <= 1'b0;
    end else if (ce) begin
      div_r <= div_nxt;
      count_r <= count_nxt;
      cca_r <= cca_nxt;
      ccb_r <= ccb_nxt;
      mode_r <= mode_nxt;
      capcmp_r <= capcmp_nxt;
      outctl_r <= outctl_nxt;
      prescale_r <= prescale_nxt;
      pout_r <= pout_nxt;
      irq1_r <= irq1_nxt;
      irq2_r <= irq2_nxt;
      rdata_r <= rdata_nxt;
      f1_r <= f1_nxt;
      f2_r <= f2_nxt;
      lvl1_r <= lvl1_nxt;
      lvl2_r <= lvl2_nxt;
    end
  end

  // Outputs come straight from flops
  assign rdata = rdata_r;
  assign pulse_output = pout_r;
  assign first_interrupt = irq1_r;
  assign second_interrupt = irq2_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_clear_zeroes_count: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && run && clr_ev) |=> (count_r == tmr_pkg::COUNT_ZERO))
    else $error("Clear edge did not zero the counter");

  a_capture_pre_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cap_b_ev) |=> (ccb_r == $past(count_r)))
    else $error("Register b did not hold the pre-clear count");

  a_wrap_sets_ovf: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && tick && !clr_ev && count_r == tmr_pkg::COUNT_MAX) |=>
    (count_r == tmr_pkg::COUNT_ZERO && mode_r[tmr_pkg::OVF_BIT]))
    else $error("Wrap did not set overflow");

  a_ovf_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && mode_r[tmr_pkg::OVF_BIT] && !(req.wr && req.addr == tmr_pkg::ADDR_MODE))
    |=> mode_r[tmr_pkg::OVF_BIT])
    else $error("Overflow flag dropped without a write");

  a_free_no_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && tick && opmode == tmr_pkg::MODE_FREE &&
     mode_nxt[tmr_pkg::MODE_HI:tmr_pkg::MODE_LO] == tmr_pkg::MODE_FREE)
    |=> (count_r == $past(count_r) + 16'h0001))
    else $error("Free-running counter did not advance");

  a_match_a_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && match_a) |=> first_interrupt)
    else $error("Match a gave no first interrupt");

  a_match_b_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && match_b) |=> second_interrupt)
    else $error("Match b gave no second interrupt");

  a_rev_phase_silent: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && capcmp_r[tmr_pkg::REV_PHASE_BIT] && !edge2 && !match_a) |=> !first_interrupt)
    else $error("Reverse-phase capture raised the first interrupt");

  a_edge_two_samples: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && lvl1_nxt != lvl1_r) |-> (f1_r[1] == f1_r[0]))
    else $error("Trigger level accepted on a single sample");

  a_count_read: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && req.rd && req.addr == tmr_pkg::ADDR_COUNT) |=> (rdata == $past(count_r)))
    else $error("Count read returned a stale value");

endmodule

// *** bench/trig_pins.sv ***
/*
 * Trigger pin source that stands in for the external signals on both
 * trigger inputs of the timer.
 * Assumes a single bench process calls drive and spaces calls itself.
 */
`timescale 1ns/1ns
module trig_pins (
  input wire logic clk,
  output logic first_trigger_input,
  output logic second_trigger_input
);
  // Pins idle low, as a pulled-down line would
  initial begin
    first_trigger_input = 1'b0;
    second_trigger_input = 1'b0;
  end

  // Level changes just after an edge and stays until the next call, so
  // the bench alone decides how long it lasts (long enough for the filter)
  task automatic drive(input logic sel, input logic lvl);
    @(posedge clk);
    if (sel) begin
      second_trigger_input <= lvl;
    end else begin
      first_trigger_input <= lvl;
    end
  endtask
endmodule

// *** bench/tb_timer_capture_compare_modes.sv ***
/*
 * Self-checking bench for the capture/compare timer: register access,
 * free-running compares and overflow, clear-and-start captures.
 * Assumes divider 0 (one tick per clock) and the trig_pins model.
 */
`timescale 1ns/1ns
module tb_timer_capture_compare_modes;
  logic clk = 1'b0;
  logic rst_n;
  logic ce;
  tmr_pkg::reg_req_s req;
  logic [15:0] rdata;
  logic first_trigger_input;
  logic second_trigger_input;
  logic pulse_output;
  logic first_interrupt;
  logic second_interrupt;
  int n_mismatch = 0;
  int n_checks = 0;
  logic seen;
  int cyc;
  logic [15:0] d, a, b, a2;

  always #50 clk = ~clk;

  timer_capture_compare_modes dut (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
    .rdata(rdata), .first_trigger_input(first_trigger_input),
    .second_trigger_input(second_trigger_input), .pulse_output(pulse_output),
    .first_interrupt(first_interrupt), .second_interrupt(second_interrupt));

  trig_pins tp (.clk(clk), .first_trigger_input(first_trigger_input),
    .second_trigger_input(second_trigger_input));

  // ----------------------------------------------------------------
  // Register port and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
    @(posedge clk);
    req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [3:0] ad, output logic [15:0] rd_val);
    @(posedge clk);
    req <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    rd_val = rdata;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Interrupts are one-cycle pulses, so every cycle is looked at
  task automatic wait_irq(input logic sel, input int lim, output logic hit, output int n);
    hit = 1'b0;
    n = 0;
    while (!hit && n < lim) begin
      @(negedge clk);
      n++;
      hit = sel ? (second_interrupt === 1'b1) : (first_interrupt === 1'b1);
    end
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Overflow wait dominates: about 66k cycles, so cut off at 95k
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped address 7 included
    for (int i = 0; i < 8; i++) begin
      rd(4'(i), d);
      chk16(d, 16'h0000);
    end
    // Free-running, both comparing, toggles on both matches
    wr(tmr_pkg::ADDR_CCA, 16'h0020);
    wr(tmr_pkg::ADDR_CCB, 16'h0040);
    wr(tmr_pkg::ADDR_OUTCTL, 16'h0007);
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    rd(tmr_pkg::ADDR_COUNT, a);
    rd(tmr_pkg::ADDR_COUNT, b);
    chk16(b - a, 16'h0002);
    // Read data stand one cycle only, then drop back to zero
    @(negedge clk);
    chk16(rdata, 16'h0000);
    wait_irq(1'b0, 200, seen, cyc);
    chk_flag(seen, 1'b1);
    repeat (2) @(negedge clk);
    chk_flag(pulse_output, 1'b1);
    wait_irq(1'b1, 200, seen, cyc);
    chk16(16'(cyc + 2), 16'h0020);
    repeat (2) @(negedge clk);
    chk_flag(pulse_output, 1'b0);
    // Wrap past the top count
    rd(tmr_pkg::ADDR_MODE, d);
    chk16(d, 16'h0004);
    for (int i = 0; i < 40000 && d[0] !== 1'b1; i++) begin
      rd(tmr_pkg::ADDR_MODE, d);
    end
    chk16(d, 16'h0005);
    rd(tmr_pkg::ADDR_COUNT, d);
    chk_flag(d < 16'h0010, 1'b1);
    rd(tmr_pkg::ADDR_MODE, d);
    chk16(d, 16'h0005);
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    rd(tmr_pkg::ADDR_MODE, d);
    chk16(d, 16'h0004);
    // Clear-and-start: a captures on second pin, b on first pin rise
    wr(tmr_pkg::ADDR_MODE, 16'h0000);
    wr(tmr_pkg::ADDR_OUTCTL, 16'h0009);
    wr(tmr_pkg::ADDR_CAPCMP, 16'h0005);
    wr(tmr_pkg::ADDR_PRESCALE, 16'h0005);
    wr(tmr_pkg::ADDR_MODE, 16'h0008);
    repeat (40) @(negedge clk);
    tp.drive(1'b1, 1'b1);
    wait_irq(1'b0, 40, seen, cyc);
    chk_flag(seen, 1'b1);
    chk_flag(pulse_output, 1'b0);
    tp.drive(1'b1, 1'b0);
    rd(tmr_pkg::ADDR_CCA, a);
    chk_flag(a > 16'h0028, 1'b1);
    tp.drive(1'b0, 1'b1);
    wait_irq(1'b1, 40, seen, cyc);
    chk_flag(seen, 1'b1);
    rd(tmr_pkg::ADDR_COUNT, d);
    chk_flag(d < 16'h0010, 1'b1);
    chk_flag(pulse_output, 1'b1);
    rd(tmr_pkg::ADDR_CCB, b);
    chk_flag(b > 16'h0030, 1'b1);
    // Reverse phase: clear on fall, a on rise without interrupt
    wr(tmr_pkg::ADDR_CAPCMP, 16'h0007);
    wr(tmr_pkg::ADDR_PRESCALE, 16'h0004);
    tp.drive(1'b0, 1'b0);
    wait_irq(1'b1, 40, seen, cyc);
    chk_flag(seen, 1'b1);
    repeat (20) @(negedge clk);
    tp.drive(1'b0, 1'b1);
    wait_irq(1'b0, 40, seen, cyc);
    chk_flag(seen, 1'b0);
    tp.drive(1'b0, 1'b0);
    wait_irq(1'b1, 40, seen, cyc);
    chk_flag(seen, 1'b1);
    rd(tmr_pkg::ADDR_CCA, a);
    rd(tmr_pkg::ADDR_CCB, b);
    chk_flag(a > 16'h0010, 1'b1);
    chk_flag((b - a) > 16'h0020, 1'b1);
    tp.drive(1'b1, 1'b1);
    wait_irq(1'b0, 40, seen, cyc);
    chk_flag(seen, 1'b1);
    rd(tmr_pkg::ADDR_CCA, a2);
    chk16(a2, a);
    tp.drive(1'b1, 1'b0);
    // Clock enable low for ten edges must freeze the counter
    rd(tmr_pkg::ADDR_COUNT, a);
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    rd(tmr_pkg::ADDR_COUNT, b);
    chk16(b - a, 16'h0003);
    // Free-running: b captures on the first trigger's falling edge, no clear
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    tp.drive(1'b0, 1'b1);
    repeat (10) @(negedge clk);
    tp.drive(1'b0, 1'b0);
    wait_irq(1'b1, 40, seen, cyc);
    chk_flag(seen, 1'b1);
    rd(tmr_pkg::ADDR_COUNT, d);
    rd(tmr_pkg::ADDR_CCB, b);
    chk16(d - b, 16'h0002);
    // Reset in mid-run returns registers and output to their idle values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_flag(pulse_output, 1'b0);
    rd(tmr_pkg::ADDR_MODE, d);
    chk16(d, 16'h0000);
    rd(tmr_pkg::ADDR_COUNT, d);
    chk16(d, 16'h0000);
    report_and_stop();
  end
endmodule
